// ==== src/subtract_swap_dirload_exec.sv ====
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module subtract_swap_dirload_exec
(
	// clock and reset
	input  wire logic                       I_CLK_SYS,
	input  wire logic                       I_SYS_RST,
	// instruction stream
	input  wire logic                       I_INSTR_VALID,
	input  wire logic [exec_pkg::INSTR_W-1:0] I_INSTR,
	// register port
	input  wire logic [7:0]                 I_ADDR,
	input  wire logic [7:0]                 I_WDATA,
	input  wire logic                       I_WR,
	input  wire logic                       I_RD,
	output logic      [7:0]                 O_RDATA,
	// core state
	output logic      [7:0]                 O_ACCUM,
	output logic      [2:0]                 O_STATUS,
	output logic      [7:0]                 O_DIR_A,
	output logic      [7:0]                 O_DIR_B,
	output logic                            O_DONE,
	output logic                            O_IGNORED
);

	logic [7:0]          file_q [0:exec_pkg::FILE_DEPTH-1];
	logic [7:0]          accum_q;
	logic [2:0]          status_q;
	logic [7:0]          dir_a_q;
	logic [7:0]          dir_b_q;
	logic [7:0]          rdata_q;
	logic                done_q;
	logic                ignored_q;
	logic                is_sub;
	logic                is_exch;
	logic                is_dir;
	logic                dest_file;
	logic [6:0]          faddr;
	logic [2:0]          dirsel;
	logic [7:0]          f_val;
	exec_pkg::alu_out_t  alu_res;
	logic                bus_file_wr;

	////////////////////////////////////////////////////////////////////////////////
	// decode

	always_comb
	begin
		faddr     = I_INSTR[exec_pkg::FADDR_HI:0];
		dest_file = (I_INSTR[exec_pkg::DEST_BIT] != exec_pkg::DEST_ACCUM);
		dirsel    = I_INSTR[exec_pkg::DIRSEL_HI:0];
		is_sub    = I_INSTR_VALID
			&& (I_INSTR[exec_pkg::OPC_HI:exec_pkg::OPC_LO] == exec_pkg::OPC_SUB_ACCUM);
		is_exch   = I_INSTR_VALID
			&& (I_INSTR[exec_pkg::OPC_HI:exec_pkg::OPC_LO] == exec_pkg::OPC_NIB_EXCH);
		is_dir    = I_INSTR_VALID
			&& (I_INSTR[exec_pkg::OPC_HI:exec_pkg::DIRPAT_LO] == exec_pkg::DIRLOAD_PAT)
			&& ((dirsel == exec_pkg::DIRSEL_A) || (dirsel == exec_pkg::DIRSEL_B));
		f_val       = file_q[faddr];
		bus_file_wr = I_WR && (I_ADDR <= exec_pkg::FILE_LAST_ADDR);
	end

	sub_swap_alu u_alu
	(
		.i_op_sel    (is_exch),
		.i_file_val  (f_val),
		.i_accum_val (accum_q),
		.o_res       (alu_res)
	);

	////////////////////////////////////////////////////////////////////////////////
	// file registers, instruction write wins over port write

	always_ff @(posedge I_CLK_SYS)
	begin
		if ((is_sub || is_exch) && dest_file)
			file_q[faddr] <= alu_res.result;
		else if (bus_file_wr)
			file_q[I_ADDR[6:0]] <= I_WDATA;
	end

	////////////////////////////////////////////////////////////////////////////////
	// accumulator

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
			accum_q <= exec_pkg::ACCUM_RST;
		else if ((is_sub || is_exch) && !dest_file)
			accum_q <= alu_res.result;
		else if (I_WR && I_ADDR == exec_pkg::ADDR_ACCUM)
			accum_q <= I_WDATA;
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
			status_q <= exec_pkg::STATUS_RST;
		else if (is_sub && alu_res.flags_update)
		begin
			status_q[exec_pkg::STAT_BORROW] <= alu_res.borrow_flag;
			status_q[exec_pkg::STAT_NIBBLE] <= alu_res.nibble_borrow_flag;
			status_q[exec_pkg::STAT_ZERO]   <= alu_res.zero_flag;
		end
		else if (I_WR && I_ADDR == exec_pkg::ADDR_STATUS && !is_exch && !is_dir)
			status_q <= I_WDATA[2:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// direction registers

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			dir_a_q <= exec_pkg::DIR_RST;
			dir_b_q <= exec_pkg::DIR_RST;
		end
		else
		begin
			if (is_dir && dirsel == exec_pkg::DIRSEL_A)
				dir_a_q <= accum_q;
			else if (I_WR && I_ADDR == exec_pkg::ADDR_DIR_A)
				dir_a_q <= I_WDATA;
			if (is_dir && dirsel == exec_pkg::DIRSEL_B)
				dir_b_q <= accum_q;
			else if (I_WR && I_ADDR == exec_pkg::ADDR_DIR_B)
				dir_b_q <= I_WDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// completion and read port

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			done_q    <= 1'b0;
			ignored_q <= 1'b0;
		end
		else
		begin
			done_q    <= is_sub || is_exch || is_dir;
			ignored_q <= I_INSTR_VALID && !(is_sub || is_exch || is_dir);
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
			rdata_q <= 8'h00;
		else if (I_RD)
		begin
			if (I_ADDR <= exec_pkg::FILE_LAST_ADDR)
				rdata_q <= file_q[I_ADDR[6:0]];
			else if (I_ADDR == exec_pkg::ADDR_ACCUM)
				rdata_q <= accum_q;
			else if (I_ADDR == exec_pkg::ADDR_STATUS)
				rdata_q <= {5'h00, status_q};
			else if (I_ADDR == exec_pkg::ADDR_DIR_A)
				rdata_q <= dir_a_q;
			else if (I_ADDR == exec_pkg::ADDR_DIR_B)
				rdata_q <= dir_b_q;
			else
				rdata_q <= 8'h00;
		end
		else
			rdata_q <= 8'h00;
	end

	always_comb
	begin
		O_RDATA   = rdata_q;
		O_ACCUM   = accum_q;
		O_STATUS  = status_q;
		O_DIR_A   = dir_a_q;
		O_DIR_B   = dir_b_q;
		O_DONE    = done_q;
		O_IGNORED = ignored_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sub_accum_value_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_sub && !dest_file |=> accum_q == 8'($past(f_val) - $past(accum_q)))
		else $error("subtract result wrong");

	sub_file_dest_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(is_sub || is_exch) && dest_file && !(I_WR && I_ADDR == exec_pkg::ADDR_ACCUM)
			|=> accum_q == $past(accum_q))
		else $error("accumulator changed with file destination");

	borrow_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_sub |=> status_q[exec_pkg::STAT_BORROW] == ($past(f_val) >= $past(accum_q))
			&& status_q[exec_pkg::STAT_ZERO] == ($past(f_val) == $past(accum_q)))
		else $error("borrow or zero flag wrong");

	nibble_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_sub |=> status_q[exec_pkg::STAT_NIBBLE]
			== ($past(f_val[3:0]) >= $past(accum_q[3:0])))
		else $error("nibble borrow flag wrong");

	exch_value_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_exch && !dest_file |=> accum_q == {$past(f_val[3:0]), $past(f_val[7:4])}
			&& $stable(status_q))
		else $error("nibble exchange wrong");

	dir_load_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_dir && dirsel == exec_pkg::DIRSEL_B |=> dir_b_q == $past(accum_q)
			&& $stable(status_q))
		else $error("direction load wrong");

	dir_a_load_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_dir && dirsel == exec_pkg::DIRSEL_A |=> dir_a_q == $past(accum_q)
			&& $stable(status_q))
		else $error("direction load to first register wrong");

	single_cycle_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(is_sub || is_exch || is_dir) |=> O_DONE ##1 (!O_DONE || $past(I_INSTR_VALID)))
		else $error("completion pulse wrong");

	cover_sub_negative_c: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_sub && f_val < accum_q);
	cover_exch_file_c: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_exch && dest_file);
	cover_dir_a_c: cover property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		is_dir && dirsel == exec_pkg::DIRSEL_A);

endmodule
`default_nettype wire

// ==== shared/exec_pkg.sv ====
package exec_pkg;

	// instruction word layout
	localparam int INSTR_W     = 14;
	localparam int OPC_HI      = 13;
	localparam int OPC_LO      = 8;
	localparam int DEST_BIT    = 7;
	localparam int FADDR_HI    = 6;
	localparam int DIRSEL_HI   = 2;
	localparam int DIRPAT_LO   = 3;
	localparam logic [5:0]  OPC_SUB_ACCUM  = 6'h02;
	localparam logic [5:0]  OPC_NIB_EXCH   = 6'h0E;
	localparam logic [10:0] DIRLOAD_PAT    = 11'h00C;
	localparam logic [2:0]  DIRSEL_A       = 3'h5;
	localparam logic [2:0]  DIRSEL_B       = 3'h6;
	localparam logic        DEST_ACCUM     = 1'b0;

	// register port map
	localparam logic [7:0] FILE_LAST_ADDR  = 8'h7F;
	localparam logic [7:0] ADDR_ACCUM      = 8'h80;
	localparam logic [7:0] ADDR_STATUS     = 8'h81;
	localparam logic [7:0] ADDR_DIR_A      = 8'h85;
	localparam logic [7:0] ADDR_DIR_B      = 8'h86;

	// status field positions and reset values
	localparam int STAT_ZERO   = 0;
	localparam int STAT_NIBBLE = 1;
	localparam int STAT_BORROW = 2;
	localparam logic [7:0] ACCUM_RST  = 8'h00;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [7:0] DIR_RST    = 8'hFF;
	localparam int FILE_DEPTH  = 128;

	typedef enum logic [1:0]
	{
		OP_SUB_ACCUM = 2'b01,
		OP_NIB_EXCH  = 2'b11,
		OP_NONE      = 2'b00
	} alu_op_t;

	typedef struct packed
	{
		logic [7:0] result;
		logic       borrow_flag;
		logic       nibble_borrow_flag;
		logic       zero_flag;
		logic       flags_update;
	} alu_out_t;

endpackage

// ==== src/sub_swap_alu.sv ====
`timescale 1ns/10ps
`default_nettype none

module sub_swap_alu
(
	// operands
	input  wire logic               i_op_sel,
	input  wire logic [7:0]         i_file_val,
	input  wire logic [7:0]         i_accum_val,
	// result
	output exec_pkg::alu_out_t      o_res
);

	logic [8:0] full_sum;
	logic [4:0] low_sum;

	// file minus accumulator, carry out means no borrow
	always_comb
	begin
		full_sum = {1'b0, i_file_val} + {1'b0, ~i_accum_val} + 9'h001;
		low_sum  = {1'b0, i_file_val[3:0]} + {1'b0, ~i_accum_val[3:0]} + 5'h01;
		o_res    = '0;
		if (i_op_sel == 1'b0)
		begin
			o_res.result             = full_sum[7:0];
			o_res.borrow_flag        = full_sum[8];
			o_res.nibble_borrow_flag = low_sum[4];
			o_res.zero_flag          = (full_sum[7:0] == 8'h00);
			o_res.flags_update       = 1'b1;
		end
		else
		begin
			o_res.result       = {i_file_val[3:0], i_file_val[7:4]};
			o_res.flags_update = 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;

	////////////////////////////////////////////////////////////////
	// bench signals
	logic                         I_CLK_SYS;
	logic                         I_SYS_RST;
	logic                         I_INSTR_VALID;
	logic [exec_pkg::INSTR_W-1:0] I_INSTR;
	logic [7:0]                   I_ADDR;
	logic [7:0]                   I_WDATA;
	logic                         I_WR;
	logic                         I_RD;
	logic [7:0]                   O_RDATA;
	logic [7:0]                   O_ACCUM;
	logic [2:0]                   O_STATUS;
	logic [7:0]                   O_DIR_A;
	logic [7:0]                   O_DIR_B;
	logic                         O_DONE;
	logic                         O_IGNORED;
	int                           n_mismatch;
	int                           tests_run;
	logic [7:0]                   fv;
	logic [7:0]                   av;
	logic [7:0]                   dv;
	logic [2:0]                   st;
	logic [7:0]                   tf [4] = '{8'h03, 8'h02, 8'h01, 8'h10};
	logic [7:0]                   ta [4] = '{8'h02, 8'h02, 8'h02, 8'h01};

	subtract_swap_dirload_exec dut
	(
		.I_CLK_SYS     (I_CLK_SYS),
		.I_SYS_RST     (I_SYS_RST),
		.I_INSTR_VALID (I_INSTR_VALID),
		.I_INSTR       (I_INSTR),
		.I_ADDR        (I_ADDR),
		.I_WDATA       (I_WDATA),
		.I_WR          (I_WR),
		.I_RD          (I_RD),
		.O_RDATA       (O_RDATA),
		.O_ACCUM       (O_ACCUM),
		.O_STATUS      (O_STATUS),
		.O_DIR_A       (O_DIR_A),
		.O_DIR_B       (O_DIR_B),
		.O_DONE        (O_DONE),
		.O_IGNORED     (O_IGNORED)
	);

	////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial
	begin
		I_CLK_SYS = 1'b0;
		forever #5 I_CLK_SYS = ~I_CLK_SYS;
	end

	initial
	begin
		#20000;
		n_mismatch++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////
	// access tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK_SYS);
		I_WR <= 1'b0;
		@(posedge I_CLK_SYS);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK_SYS);
		I_RD <= 1'b0;
		#1 check(O_RDATA, exp);
		@(posedge I_CLK_SYS);
		#1 check(O_RDATA, 8'h00);
		@(posedge I_CLK_SYS);
	endtask

	task automatic run(input logic [13:0] ins, input logic [1:0] flags);
		I_INSTR <= ins;
		I_INSTR_VALID <= 1'b1;
		@(posedge I_CLK_SYS);
		I_INSTR_VALID <= 1'b0;
		#1 check({6'h00, O_DONE, O_IGNORED}, {6'h00, flags});
		@(posedge I_CLK_SYS);
	endtask

	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		n_mismatch = 0;
		tests_run = 0;
		I_SYS_RST = 1'b1;
		I_INSTR_VALID = 1'b0;
		I_INSTR = '0;
		I_ADDR = 8'h00;
		I_WDATA = 8'h00;
		I_WR = 1'b0;
		I_RD = 1'b0;
		repeat (2) @(posedge I_CLK_SYS);
		I_SYS_RST <= 1'b0;
		@(posedge I_CLK_SYS);
		rd(exec_pkg::ADDR_ACCUM, exec_pkg::ACCUM_RST);
		rd(exec_pkg::ADDR_DIR_A, exec_pkg::DIR_RST);
		check({5'h00, O_STATUS}, {5'h00, exec_pkg::STATUS_RST});
		// subtract table, both destinations
		for (int i = 0; i < 4; i++)
		begin
			fv = tf[i];
			av = ta[i];
			dv = fv - av;
			wr(8'h10 + 8'(i), fv);
			wr(exec_pkg::ADDR_ACCUM, av);
			run({exec_pkg::OPC_SUB_ACCUM, i[0], 7'h10 + 7'(i)}, 2'b10);
			st = {fv >= av, fv[3:0] >= av[3:0], dv == 8'h00};
			check({5'h00, O_STATUS}, {5'h00, st});
			check(O_ACCUM, i[0] ? av : dv);
			rd(8'h10 + 8'(i), i[0] ? dv : fv);
		end
		// nibble exchange, flags kept
		wr(8'h20, 8'hA5);
		run({exec_pkg::OPC_NIB_EXCH, 1'b0, 7'h20}, 2'b10);
		check(O_ACCUM, 8'h5A);
		run({exec_pkg::OPC_NIB_EXCH, 1'b1, 7'h20}, 2'b10);
		rd(8'h20, 8'h5A);
		check({5'h00, O_STATUS}, {5'h00, st});
		// back to back: exchange then direction load
		I_INSTR <= {exec_pkg::OPC_NIB_EXCH, 1'b0, 7'h20};
		I_INSTR_VALID <= 1'b1;
		@(posedge I_CLK_SYS);
		I_INSTR <= 14'h0065;
		#1 check({7'h00, O_DONE}, 8'h01);
		@(posedge I_CLK_SYS);
		I_INSTR_VALID <= 1'b0;
		#1 check(O_DIR_A, 8'hA5);
		check({7'h00, O_DONE}, 8'h01);
		@(posedge I_CLK_SYS);
		run(14'h0066, 2'b10);
		check(O_DIR_B, 8'hA5);
		check({5'h00, O_STATUS}, {5'h00, st});
		// refused operand and foreign opcode
		run(14'h0067, 2'b01);
		run(14'h3A00, 2'b01);
		check(O_ACCUM, 8'hA5);
		// direction register written by address
		wr(exec_pkg::ADDR_DIR_B, 8'h3C);
		rd(exec_pkg::ADDR_DIR_B, 8'h3C);
		rd(8'h90, 8'h00);
		give_verdict();
	end

endmodule

`default_nettype wire
